// File: src/smbid_pkg.sv
package smbid_pkg;

  // byte addresses of the upper control space
  localparam logic [7:0] SMBID_OFS_RSVD_A = 8'h04;
  localparam logic [7:0] SMBID_OFS_MAKER  = 8'h05;
  localparam logic [7:0] SMBID_OFS_PART   = 8'h06;
  localparam logic [7:0] SMBID_OFS_LEN    = 8'h07;
  localparam logic [7:0] SMBID_OFS_RSVD_B = 8'h08;

  // widths and field positions
  localparam int SMBID_AW      = 8;
  localparam int SMBID_DW      = 8;
  localparam int SMBID_LEN_W   = 5;
  localparam int SMBID_LEN_MSB = 4;
  localparam int SMBID_LEN_LSB = 0;
  localparam int SMBID_REV_MSB = 7;
  localparam int SMBID_REV_LSB = 4;
  localparam int SMBID_MKR_MSB = 3;
  localparam int SMBID_MKR_LSB = 0;

  // reset values
  localparam logic [4:0] SMBID_LEN_RST  = 5'h08;
  localparam logic [5:0] SMBID_CNT_RST  = 6'h09;
  localparam logic [7:0] SMBID_ZERO     = 8'h00;
  localparam logic [2:0] SMBID_LEN_PAD  = 3'h0;

  // one byte access from the protocol engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } smbid_req_t;

endpackage : smbid_pkg

// File: src/smbid_regs.sv
`timescale 1ns/1ns

module smbid_regs
  import smbid_pkg::*;
#(
  parameter logic [3:0] REVISION_CODE = 4'h3,  // arbitrary value
  parameter logic [3:0] MAKER_CODE    = 4'h5,  // arbitrary value
  parameter logic [7:0] PART_CODE     = 8'h5a  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  smbid_req_t       req,
  output logic [7:0]       rd_data_q,
  output logic             rd_valid_q,
  output logic             rd_hit_q,
  output logic [4:0]       read_length_q,
  output logic [5:0]       block_bytes_q
);

  // read selection for one byte address
  function automatic logic [7:0] smbid_rd_mux(input logic [7:0] a, input logic [4:0] len);
    logic [7:0] v;
    v = SMBID_ZERO;
    case (a)
      SMBID_OFS_MAKER: v = {REVISION_CODE, MAKER_CODE};
      SMBID_OFS_PART:  v = PART_CODE;
      SMBID_OFS_LEN:   v = {SMBID_LEN_PAD, len};
      default:         v = SMBID_ZERO;
    endcase
    return v;
  endfunction : smbid_rd_mux

  // address decode
  wire logic       hit_w;
  wire logic       len_wr_w;
  wire logic [7:0] rd_sel_w;
  wire logic [4:0] read_length_d;
  wire logic [5:0] block_bytes_d;

  assign hit_w         = (req.addr >= SMBID_OFS_RSVD_A) && (req.addr <= SMBID_OFS_RSVD_B);
  assign len_wr_w      = req.wr && (req.addr == SMBID_OFS_LEN);  // only byte 7 takes writes
  assign rd_sel_w      = smbid_rd_mux(req.addr, read_length_q);
  assign read_length_d = len_wr_w ? req.data[SMBID_LEN_MSB:SMBID_LEN_LSB]
                                  : read_length_q;
  assign block_bytes_d = {1'b0, read_length_d} + 6'h01;          // count plus one

  // length register and the derived byte total
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_length_q <= SMBID_LEN_RST;
      block_bytes_q <= SMBID_CNT_RST;
    end else begin
      read_length_q <= read_length_d;
      block_bytes_q <= block_bytes_d;
    end
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q  <= SMBID_ZERO;
      rd_valid_q <= 1'b0;
      rd_hit_q   <= 1'b0;
    end else begin
      rd_data_q  <= req.rd ? rd_sel_w : SMBID_ZERO;
      rd_valid_q <= req.rd;
      rd_hit_q   <= req.rd && hit_w;
    end
  end

  // checks
  // the count and its byte total sit at their defaults just after reset
  property p_len_rst;
    @(posedge clk) $past(sys_rst) |-> (read_length_q == SMBID_LEN_RST) &&
                                      (block_bytes_q == SMBID_CNT_RST);
  endproperty
  a_len_rst: assert property (p_len_rst) else $error("length not 8 after reset");

  // a write to byte 7 lands in the count one edge later
  property p_len_wr;
    @(posedge clk) disable iff (sys_rst)
      (req.wr && req.addr == SMBID_OFS_LEN) |=>
        read_length_q == $past(req.data[SMBID_LEN_MSB:SMBID_LEN_LSB]);
  endproperty
  a_len_wr: assert property (p_len_wr) else $error("length write lost");

  // without a write to byte 7 the count never moves
  property p_len_hold;
    @(posedge clk) disable iff (sys_rst)
      !(req.wr && req.addr == SMBID_OFS_LEN) |=> $stable(read_length_q);
  endproperty
  a_len_hold: assert property (p_len_hold) else $error("length changed without write");

  // the byte total always tracks the count plus one
  property p_bytes;
    @(posedge clk) disable iff (sys_rst)
      block_bytes_q == ({1'b0, read_length_q} + 6'h01);
  endproperty
  a_bytes: assert property (p_bytes) else $error("byte total not length plus one");

  // byte 5 answers revision code high, maker code low
  property p_maker;
    @(posedge clk) disable iff (sys_rst)
      (req.rd && req.addr == SMBID_OFS_MAKER) |=>
        rd_data_q == {REVISION_CODE, MAKER_CODE} && rd_hit_q;
  endproperty
  a_maker: assert property (p_maker) else $error("revision byte wrong");

  // byte 6 answers the fixed part code
  property p_part;
    @(posedge clk) disable iff (sys_rst)
      (req.rd && req.addr == SMBID_OFS_PART) |=> rd_data_q == PART_CODE;
  endproperty
  a_part: assert property (p_part) else $error("part byte wrong");

  // reserved bytes answer all zero
  property p_rsvd;
    @(posedge clk) disable iff (sys_rst)
      (req.rd && (req.addr == SMBID_OFS_RSVD_A || req.addr == SMBID_OFS_RSVD_B)) |=>
        rd_data_q == SMBID_ZERO;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");

  // byte 7 answers the count held before the read edge
  property p_len_rd;
    @(posedge clk) disable iff (sys_rst)
      (req.rd && req.addr == SMBID_OFS_LEN) |=>
        rd_data_q == {SMBID_LEN_PAD, $past(read_length_q)};
  endproperty
  a_len_rd: assert property (p_len_rd) else $error("length readback wrong");

  // each read strobe gives one answer pulse, one edge later
  property p_valid;
    @(posedge clk) disable iff (sys_rst)
      req.rd |=> rd_valid_q ##1 (rd_valid_q == $past(req.rd));
  endproperty
  a_valid: assert property (p_valid) else $error("read answer timing wrong");

  // nothing answers in a cycle without a read strobe
  property p_idle;
    @(posedge clk) disable iff (sys_rst)
      !req.rd |=> (rd_data_q == SMBID_ZERO) && !rd_valid_q && !rd_hit_q;
  endproperty
  a_idle: assert property (p_idle) else $error("read answer without a read");

  // a write on its own never raises a read answer
  property p_wr_quiet;
    @(posedge clk) disable iff (sys_rst)
      (req.wr && !req.rd) |=> !rd_valid_q;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write gave a read answer");

  // an answer pulse only ever follows a read strobe
  property p_answer_src;
    @(posedge clk) disable iff (sys_rst)
      rd_valid_q |-> $past(req.rd);
  endproperty
  a_answer_src: assert property (p_answer_src) else $error("answer without strobe");

  // a write to byte 7 moves the byte total to the new count plus one
  property p_len_wr_total;
    @(posedge clk) disable iff (sys_rst)
      (req.wr && req.addr == SMBID_OFS_LEN) |=>
        block_bytes_q == ({1'b0, $past(req.data[SMBID_LEN_MSB:SMBID_LEN_LSB])} + 6'h01);
  endproperty
  a_len_wr_total: assert property (p_len_wr_total) else $error("byte total not updated");

  // writes to read-only and reserved bytes leave the count alone
  property p_ro_hold;
    @(posedge clk) disable iff (sys_rst)
      (req.wr && req.addr != SMBID_OFS_LEN) |=>
        $stable(read_length_q) && $stable(block_bytes_q);
  endproperty
  a_ro_hold: assert property (p_ro_hold) else $error("count moved on other write");

  // any read inside bytes 4..8 is flagged as a hit
  property p_hit;
    @(posedge clk) disable iff (sys_rst)
      (req.rd && (req.addr >= SMBID_OFS_RSVD_A) && (req.addr <= SMBID_OFS_RSVD_B)) |=>
        rd_valid_q && rd_hit_q;
  endproperty
  a_hit: assert property (p_hit) else $error("mapped read not flagged");

  // reads outside bytes 4..8 answer zero and no hit
  property p_unmapped;
    @(posedge clk) disable iff (sys_rst)
      (req.rd && ((req.addr < SMBID_OFS_RSVD_A) || (req.addr > SMBID_OFS_RSVD_B))) |=>
        rd_valid_q && !rd_hit_q && (rd_data_q == SMBID_ZERO);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // reserved bytes read bit 0 as zero
  property p_rsvd_bit0;
    @(posedge clk) disable iff (sys_rst)
      (req.rd && ((req.addr == SMBID_OFS_RSVD_A) || (req.addr == SMBID_OFS_RSVD_B))) |=>
        !rd_data_q[0];
  endproperty
  a_rsvd_bit0: assert property (p_rsvd_bit0) else $error("reserved bit 0 set");

  // the unused top bits of byte 7 read zero
  property p_len_pad;
    @(posedge clk) disable iff (sys_rst)
      (req.rd && req.addr == SMBID_OFS_LEN) |=>
        rd_data_q[SMBID_DW-1:SMBID_LEN_MSB+1] == SMBID_LEN_PAD;
  endproperty
  a_len_pad: assert property (p_len_pad) else $error("count top bits not zero");

  // while reset is held every register sits at its reset value
  property p_in_rst;
    @(posedge clk)
      sys_rst |-> (read_length_q == SMBID_LEN_RST) && (block_bytes_q == SMBID_CNT_RST) &&
                  !rd_valid_q && !rd_hit_q && (rd_data_q == SMBID_ZERO);
  endproperty
  a_in_rst: assert property (p_in_rst) else $error("register not at reset value");

  // main scenarios: count write then readback, id reads, id writes, last byte, reset release
  c_len_wr: cover property (@(posedge clk) disable iff (sys_rst)
    (req.wr && req.addr == SMBID_OFS_LEN) ##1 (req.rd && req.addr == SMBID_OFS_LEN));
  c_maker_rd: cover property (@(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == SMBID_OFS_MAKER);
  c_id_wr: cover property (@(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == SMBID_OFS_PART);
  c_last_byte: cover property (@(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == SMBID_OFS_RSVD_B);
  c_rst_release: cover property (@(posedge clk)
    $fell(sys_rst));

endmodule : smbid_regs

// File: test/smbid_host.sv
`timescale 1ns/1ns
module smbid_host
  import smbid_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rd_data_q,
  output smbid_req_t      req
);
  initial req = '0;
  // one write strobe, taken at a single edge; returns once the write has settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '0;
    #1;
  endtask : wr
  // one read strobe, answer taken once that edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    #1 d = rd_data_q;
  endtask : rd
  // block read from byte 0: one single-byte read per address, n bytes in turn, counting each
  task automatic blk(input int n, output int cnt);
    logic [7:0] d;
    cnt = 0;
    for (int i = 0; i < n; i++) begin
      rd(8'(i), d);
      cnt++;
    end
  endtask : blk
endmodule : smbid_host

// File: test/smbid_regs_test.sv
`timescale 1ns/1ns
module smbid_regs_test;
  import smbid_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst;
  smbid_req_t req;
  logic [7:0] rd_data_q;
  logic       rd_valid_q;
  logic       rd_hit_q;
  logic [4:0] read_length_q;
  logic [5:0] block_bytes_q;
  logic [7:0] v;
  int         n;
  int         fails = 0;
  int         tests_run = 0;
  smbid_regs #(.REVISION_CODE(4'h3), .MAKER_CODE(4'h5), .PART_CODE(8'h5a)) u_smbid_regs (
    .clk(clk), .sys_rst(sys_rst), .req(req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .rd_hit_q(rd_hit_q), .read_length_q(read_length_q), .block_bytes_q(block_bytes_q));
  smbid_host u_smbid_host (.clk(clk), .rd_data_q(rd_data_q), .req(req));
  // clock at 100 ns period
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic test_done;
    $display("mismatches %0d of %0d compares", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // read, try to overwrite, read again: value must not move
  task automatic t_fixed(input logic [7:0] a, input logic [7:0] e);
    u_smbid_host.rd(a, v);
    chk(v, e);
    chk({6'h0, rd_valid_q, rd_hit_q}, 8'h03);
    u_smbid_host.wr(a, 8'hff);
    chk({3'h0, read_length_q}, 8'h08);
    u_smbid_host.rd(a, v);
    chk(v, e);
  endtask : t_fixed
  task automatic t_len;
    u_smbid_host.wr(SMBID_OFS_LEN, 8'hff);
    u_smbid_host.rd(SMBID_OFS_LEN, v);
    chk(v, 8'h1f);
    chk({2'h0, block_bytes_q}, 8'h20);
    u_smbid_host.wr(SMBID_OFS_LEN, 8'h00);
    chk({2'h0, block_bytes_q}, 8'h01);
    u_smbid_host.wr(SMBID_OFS_LEN, 8'h08);
    u_smbid_host.rd(8'h09, v);
    chk(v, 8'h00);
    chk({7'h0, rd_hit_q}, 8'h00);
  endtask : t_len
  task automatic t_block;
    chk({3'h0, read_length_q}, 8'h08);
    u_smbid_host.blk(int'(block_bytes_q), n);
    chk(8'(n), 8'h09);
  endtask : t_block
  // reset in mid-run brings the count back to its default
  task automatic t_reset;
    u_smbid_host.wr(SMBID_OFS_LEN, 8'h03);
    chk({2'h0, block_bytes_q}, 8'h04);
    @(posedge clk) sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({3'h0, read_length_q}, 8'h08);
    chk({2'h0, block_bytes_q}, 8'h09);
    chk({6'h0, rd_valid_q, rd_hit_q}, 8'h00);
    @(posedge clk) sys_rst <= 1'b0;
  endtask : t_reset
  // watchdog well past the expected run
  initial begin
    #200000;
    fails++;
    test_done();
  end
  initial begin
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_block();
    t_fixed(SMBID_OFS_MAKER, 8'h35);
    t_fixed(SMBID_OFS_PART, 8'h5a);
    t_fixed(SMBID_OFS_RSVD_A, 8'h00);
    t_fixed(SMBID_OFS_RSVD_B, 8'h00);
    t_reset();
    t_len();
    t_block();
    test_done();
  end
endmodule : smbid_regs_test
